// file: logic/irms_i2c_regs.sv
/*
 * Two-wire target interface and the three sensor registers.
 * Assumes scl and sda come asynchronously from pins, the direction
 * codes come from logic on clk_sys, and the pad resolves sda_oe.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Answer address 1010101, then direction bit
// - Work at any clock up to 400kHz
// - Sample data only while clock high
// - Start: data falls, clock high; compare address
// - Pull data low on ninth pulse if matched
// - Receive and acknowledge register index byte
// - Acknowledge data byte, store in indexed register
// - Stop: data rises, clock high; ends transfer
// - Repeated start with read returns indexed register; code returns status at index 00h and 00h for every other index
// - Status at index 00h, read only
// - Bits 3:2 give proximity direction
// - Bits 1:0 give lateral motion direction
// - Status bits 7:4 unused
// - Shutdown at 01h, bit 0, resets zero
// - Config at 11h, fields 3:1 and 0
// - Bit 0 low means shutdown; contents kept
// - Current code selects 400/280/210/70 mA
// - Config bit 0 selects proximity mode
// - Interrupt low on change; release read or 10ms
module irms_i2c_regs
	import irms_pkg::*;
#(
	parameter int unsigned IRQ_HOLD_CYC = `IRMS_IRQ_HOLD_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [1:0] proximity_direction,
	input wire logic [1:0] lateral_motion_direction,
	output logic soft_shutdown_n,
	output logic device_active,
	output logic [2:0] emitter_current_sel,
	output irms_ec_level_t emitter_level,
	output logic proximity_mode,
	output logic irq_out_n
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic scl_m_r, scl_s_r, scl_q_r;
	logic sda_m_r, sda_s_r, sda_q_r;

	// Third stage only feeds edge detection
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{scl_m_r, scl_s_r, scl_q_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_q_r} <= 3'h7;
		end else begin
			{scl_m_r, scl_s_r, scl_q_r} <= {scl_i, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_q_r} <= {sda_i, sda_m_r, sda_s_r};
		end
	end

	wire scl_rise = scl_s_r & ~scl_q_r;
	wire scl_fall = ~scl_s_r & scl_q_r;
	wire scl_held = scl_s_r & scl_q_r;
	wire start_det = scl_held & sda_q_r & ~sda_s_r;
	wire stop_det = scl_held & ~sda_q_r & sda_s_r;

	// ****************************************
	// Bus state machine
	// ****************************************
	irms_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] index_r, index_nxt;
	logic rw_r, rw_nxt;
	logic drive_r, drive_nxt;
	logic nack_r, nack_nxt;
	logic wr_pulse, rd_status;

	logic [7:0] status_r;
	logic [7:0] sd_reg_r;
	logic [7:0] cfg_reg_r;

	function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] ref_idx);
		idx_is = (idx == ref_idx);
	endfunction : idx_is

	wire [7:0] shift_in = {shift_r[6:0], sda_s_r};
	wire addr_match = (shift_r[7:1] == `IRMS_TARGET_ADDR);
	wire [7:0] read_data = idx_is(index_r, `IRMS_IDX_MOTION_STATUS) ? status_r :
		`IRMS_READ_UNMAPPED;
	wire byte_done = (cnt_r == 4'h8);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		index_nxt = index_r;
		rw_nxt = rw_r;
		drive_nxt = drive_r;
		nack_nxt = nack_r;
		wr_pulse = 1'b0;
		rd_status = 1'b0;
		if (start_det) begin
			// Repeated start keeps the index for the read phase
			state_nxt = ST_ADDR;
			cnt_nxt = 4'h0;
			drive_nxt = 1'b0;
		end else if (stop_det) begin
			state_nxt = ST_IDLE;
			drive_nxt = 1'b0;
		end else if (scl_rise) begin
			unique case (state_r)
				ST_ADDR, ST_INDEX, ST_WDATA: begin
					shift_nxt = shift_in;
					cnt_nxt = cnt_r + 4'h1;
				end
				ST_RDATA: cnt_nxt = cnt_r + 4'h1;
				ST_RACK: nack_nxt = sda_s_r;
				default: ;
			endcase
		end else if (scl_fall) begin
			unique case (state_r)
				ST_ADDR: if (byte_done) begin
					if (addr_match) begin
						state_nxt = ST_ACK_ADDR;
						drive_nxt = 1'b1;
						rw_nxt = shift_r[0];
					end else begin
						state_nxt = ST_IDLE;
					end
				end
				ST_ACK_ADDR: begin
					cnt_nxt = 4'h0;
					if (rw_r) begin
						state_nxt = ST_RDATA;
						shift_nxt = read_data;
						drive_nxt = ~read_data[7];
						rd_status = idx_is(index_r, `IRMS_IDX_MOTION_STATUS);
					end else begin
						state_nxt = ST_INDEX;
						drive_nxt = 1'b0;
					end
				end
				ST_INDEX: if (byte_done) begin
					index_nxt = shift_r;
					state_nxt = ST_ACK_INDEX;
					drive_nxt = 1'b1;
				end
				ST_ACK_INDEX, ST_ACK_WDATA: begin
					state_nxt = ST_WDATA;
					cnt_nxt = 4'h0;
					drive_nxt = 1'b0;
				end
				ST_WDATA: if (byte_done) begin
					wr_pulse = 1'b1;
					state_nxt = ST_ACK_WDATA;
					drive_nxt = 1'b1;
				end
				ST_RDATA: begin
					if (byte_done) begin
						state_nxt = ST_RACK;
						drive_nxt = 1'b0;
					end else begin
						shift_nxt = {shift_r[6:0], 1'b0};
						drive_nxt = ~shift_r[6];
					end
				end
				ST_RACK: begin
					cnt_nxt = 4'h0;
					if (nack_r) begin
						state_nxt = ST_IDLE;
					end else begin
						state_nxt = ST_RDATA;
						shift_nxt = read_data;
						drive_nxt = ~read_data[7];
						rd_status = idx_is(index_r, `IRMS_IDX_MOTION_STATUS);
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			index_r <= 8'h00;
			rw_r <= 1'b0;
			drive_r <= 1'b0;
			nack_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			index_r <= index_nxt;
			rw_r <= rw_nxt;
			drive_r <= drive_nxt;
			nack_r <= nack_nxt;
		end
	end

	// Open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe = drive_r;

	// ****************************************
	// Registers
	// ****************************************
	wire wr_sd = wr_pulse & idx_is(index_r, `IRMS_IDX_SOFT_POWER_DOWN);
	wire wr_cfg = wr_pulse & idx_is(index_r, `IRMS_IDX_OPERATING_CONFIG);
	wire [7:0] status_nxt = {4'h0, proximity_direction, lateral_motion_direction};
	wire status_chg = (status_nxt != status_r);

	// Status resets to zero only so simulation starts defined
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= `IRMS_RST_MOTION_STATUS;
			sd_reg_r <= `IRMS_RST_SOFT_POWER_DOWN;
			cfg_reg_r <= `IRMS_RST_OPERATING_CONFIG;
		end else begin
			status_r <= status_nxt;
			if (wr_sd) sd_reg_r <= shift_r;
			if (wr_cfg) cfg_reg_r <= shift_r;
		end
	end

	// Shutdown gates activity only; registers keep contents
	assign soft_shutdown_n = sd_reg_r[`IRMS_SSD_BIT];
	assign device_active = sd_reg_r[`IRMS_SSD_BIT];
	assign emitter_current_sel = cfg_reg_r[`IRMS_EC_MSB:`IRMS_EC_LSB];
	assign emitter_level = emitter_current_sel[2] ? EC_70MA :
		emitter_current_sel[1] ? EC_210MA :
		emitter_current_sel[0] ? EC_280MA : EC_400MA;
	assign proximity_mode = cfg_reg_r[`IRMS_MODE_BIT];

	// ****************************************
	// Interrupt
	// ****************************************
	logic irq_r;
	logic [31:0] irq_cnt_r;
	wire irq_timeout = irq_r & (irq_cnt_r >= IRQ_HOLD_CYC - 1);

	// A change in the clearing cycle keeps the line low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_r <= 1'b0;
			irq_cnt_r <= 32'h0;
		end else begin
			if (status_chg) irq_r <= 1'b1;
			else if (rd_status | irq_timeout) irq_r <= 1'b0;
			// Clearing on release too keeps the count below the hold
			if (status_chg | ~irq_r | rd_status | irq_timeout) irq_cnt_r <= 32'h0;
			else irq_cnt_r <= irq_cnt_r + 32'h1;
		end
	end

	assign irq_out_n = ~irq_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_start_to_addr: assert property (start_det |=> state_r == ST_ADDR)
		else $error("start not seen");
	a_stop_to_idle: assert property (stop_det |=> state_r == ST_IDLE && !sda_oe)
		else $error("stop not seen");
	a_ack_on_match: assert property (
		scl_fall && state_r == ST_ADDR && byte_done
		&& addr_match && !start_det && !stop_det |=> sda_oe [*1])
		else $error("no address ack");
	a_no_ack_other: assert property (
		scl_fall && state_r == ST_ADDR && byte_done
		&& !addr_match && !start_det && !stop_det |=> !sda_oe && state_r == ST_IDLE)
		else $error("acked foreign address");
	a_sda_change_low: assert property (
		$changed(sda_oe) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
		else $error("sda moved while scl high");
	a_sd_write: assert property (wr_sd |=> soft_shutdown_n == $past(shift_r[0]))
		else $error("shutdown write lost");
	a_cfg_write: assert property (
		wr_cfg |=> proximity_mode == $past(shift_r[0])
		&& emitter_current_sel == $past(shift_r[3:1]))
		else $error("config write lost");
	a_status_follow: assert property (
		##1 status_r == {4'h0, $past(proximity_direction), $past(lateral_motion_direction)})
		else $error("status stale");
	a_irq_assert: assert property (status_chg |=> !irq_out_n)
		else $error("irq missed change");
	a_irq_bound: assert property (irq_cnt_r < IRQ_HOLD_CYC)
		else $error("irq held too long");
	a_status_ro: assert property (
		wr_pulse && idx_is(index_r, `IRMS_IDX_MOTION_STATUS) |=> $stable(sd_reg_r) && $stable(cfg_reg_r))
		else $error("status write leaked");

	a_index_store: assert property (
		scl_fall && state_r == ST_INDEX && byte_done |=> index_r == $past(shift_r) && sda_oe)
		else $error("index not taken");
	a_wdata_ack: assert property (wr_pulse |=> sda_oe)
		else $error("no data ack");
	a_ack_release: assert property (
		scl_fall && state_r == ST_ACK_ADDR && !rw_r |=> !sda_oe && state_r == ST_INDEX)
		else $error("address ack not released");
	a_wdata_release: assert property (
		scl_fall && (state_r == ST_ACK_INDEX || state_r == ST_ACK_WDATA) |=> !sda_oe)
		else $error("byte ack not released");
	a_read_load: assert property (
		scl_fall && state_r == ST_ACK_ADDR && rw_r |=> state_r == ST_RDATA && sda_oe == !$past(read_data[7]))
		else $error("read byte not loaded");
	a_rack_no_drive: assert property (state_r == ST_RACK |-> !sda_oe)
		else $error("drove during controller ack");
	a_nack_idle: assert property (
		scl_fall && state_r == ST_RACK && nack_r |=> state_r == ST_IDLE)
		else $error("read went on after nack");
	a_idle_released: assert property (state_r == ST_IDLE |-> !sda_oe)
		else $error("sda pulled while idle");
	a_status_upper: assert property (status_r[7:4] == 4'h0)
		else $error("unused status bits set");
	a_irq_release: assert property (rd_status && !status_chg |=> irq_out_n)
		else $error("irq kept after read");
	a_irq_timeout: assert property (irq_timeout && !status_chg |=> irq_out_n)
		else $error("irq kept after hold");
	a_irq_cnt_idle: assert property (!irq_r |-> irq_cnt_r == 32'h0)
		else $error("hold count runs while released");
	a_regs_kept: assert property (!wr_sd && !wr_cfg |=> $stable(sd_reg_r) && $stable(cfg_reg_r))
		else $error("register changed without write");

	c_write_done: cover property (wr_cfg);
	c_read_status: cover property (rd_status);
	c_irq_timeout: cover property (irq_timeout && !status_chg);
	c_master_nack: cover property (state_r == ST_RACK && scl_fall && nack_r);
	c_addr_mismatch: cover property (scl_fall && state_r == ST_ADDR && byte_done && !addr_match);

endmodule : irms_i2c_regs

`default_nettype wire

// file: logic/irms_regs.svh
/*
 * Register map, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the bench.
 */
`ifndef IRMS_REGS_SVH
`define IRMS_REGS_SVH

// ****************************************
// Bus address
// ****************************************
`define IRMS_TARGET_ADDR 7'h55

// ****************************************
// Register indices and resets
// ****************************************
`define IRMS_IDX_MOTION_STATUS 8'h00
`define IRMS_IDX_SOFT_POWER_DOWN 8'h01
`define IRMS_IDX_OPERATING_CONFIG 8'h11
`define IRMS_RST_SOFT_POWER_DOWN 8'h00
`define IRMS_RST_OPERATING_CONFIG 8'h00
`define IRMS_RST_MOTION_STATUS 8'h00
`define IRMS_READ_UNMAPPED 8'h00

// ****************************************
// Field positions
// ****************************************
`define IRMS_SSD_BIT 0
`define IRMS_MODE_BIT 0
`define IRMS_EC_MSB 3
`define IRMS_EC_LSB 1

// ****************************************
// Timing
// ****************************************
`define IRMS_CLK_SYS_KHZ 50000
`define IRMS_SCL_MAX_KHZ 400
`define IRMS_IRQ_HOLD_MS 10
`define IRMS_IRQ_HOLD_CYC (`IRMS_IRQ_HOLD_MS * `IRMS_CLK_SYS_KHZ)

`endif

// file: logic/irms_pkg.sv
/*
 * Types for the sensor register interface.
 * Assumes the register header sits on the include path.
 */
`default_nettype none
package irms_pkg;
	`include "irms_regs.svh"

	// ****************************************
	// Bus state
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_INDEX,
		ST_ACK_INDEX,
		ST_WDATA,
		ST_ACK_WDATA,
		ST_RDATA,
		ST_RACK
	} irms_state_t;

	typedef enum logic [1:0] {
		EC_400MA,
		EC_280MA,
		EC_210MA,
		EC_70MA
	} irms_ec_level_t;
endpackage : irms_pkg
`default_nettype wire

// file: verification/irms_host_model.sv
/* Two-wire bus controller model for the sensor bench.
 * Assumes the bench resolves a pulled-up data line from all pulls. */
`timescale 1ns/1ps
`default_nettype none
module irms_host_model (
	output var logic scl,
	output var logic sda_pull,
	input wire logic sda
);
	// ****************
	// Bit level, 160 ns per bit
	// ****************
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic start();
		#40 sda_pull = 1'b0;
		#40 scl = 1'b1;
		#80 sda_pull = 1'b1;
		#80 scl = 1'b0;
	endtask : start
	task automatic stop();
		#40 sda_pull = 1'b1;
		#40 scl = 1'b1;
		#80 sda_pull = 1'b0;
		#80;
	endtask : stop
	// Data moves only mid-low, so it is stable over the high phase
	task automatic bit_tx(input logic b);
		#40 sda_pull = ~b;
		#40 scl = 1'b1;
		#80 scl = 1'b0;
	endtask : bit_tx
	task automatic bit_rx(output logic b);
		#40 sda_pull = 1'b0;
		#40 scl = 1'b1;
		#40 b = sda;
		#40 scl = 1'b0;
	endtask : bit_rx
	task automatic put_byte(input logic [7:0] d, output logic ack_n);
		for (int i = 7; i >= 0; i--) bit_tx(d[i]);
		bit_rx(ack_n);
	endtask : put_byte
	task automatic get_byte(output logic [7:0] d, input logic nack);
		for (int i = 7; i >= 0; i--) bit_rx(d[i]);
		bit_tx(nack);
	endtask : get_byte
endmodule : irms_host_model
`default_nettype wire

// file: verification/ir_motion_sensor_i2c_regs_bench.sv
/* Self-checking bench for the sensor register interface.
 * Assumes the host model and the design package are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "irms_regs.svh"
module ir_motion_sensor_i2c_regs_bench;
	import irms_pkg::*;
	// Short hold keeps the auto-release test cheap
	localparam int HOLD = 1000;
	logic clk_sys, rst_n, scl, host_pull, sda_o, sda_oe, ssd_n, act, pmode, irq_n, ack_n;
	logic [1:0] prox, lat;
	logic [2:0] ec;
	logic [7:0] rd_v;
	irms_ec_level_t lvl;
	int err_total, num_checks;
	wire logic sda = ~(host_pull | (sda_oe & ~sda_o));
	irms_i2c_regs #(.IRQ_HOLD_CYC(HOLD)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.proximity_direction(prox), .lateral_motion_direction(lat),
		.soft_shutdown_n(ssd_n), .device_active(act), .emitter_current_sel(ec),
		.emitter_level(lvl), .proximity_mode(pmode), .irq_out_n(irq_n));
	irms_host_model i_host (.scl(scl), .sda_pull(host_pull), .sda(sda));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		i_host.start();
		i_host.put_byte({`IRMS_TARGET_ADDR, 1'b0}, ack_n);
		chk({7'h0, ack_n}, 8'h00);
		i_host.put_byte(idx, ack_n);
		chk({7'h0, ack_n}, 8'h00);
		i_host.put_byte(d, ack_n);
		chk({7'h0, ack_n}, 8'h00);
		i_host.stop();
		repeat (4) @(negedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		i_host.start();
		i_host.put_byte({`IRMS_TARGET_ADDR, 1'b0}, ack_n);
		i_host.put_byte(idx, ack_n);
		i_host.start();
		i_host.put_byte({`IRMS_TARGET_ADDR, 1'b1}, ack_n);
		chk({7'h0, ack_n}, 8'h00);
		i_host.get_byte(d, 1'b1);
		i_host.stop();
		repeat (4) @(negedge clk_sys);
	endtask : rd
	function automatic logic [1:0] lvl_of(input logic [2:0] c);
		return c[2] ? 2'h3 : (c[1] ? 2'h2 : {1'b0, c[0]});
	endfunction : lvl_of
	// ****************
	// Sequence
	// ****************
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// About 25000 clocks, several times the sequence
	initial begin
		#500000;
		err_total++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		prox = 2'h0;
		lat = 2'h0;
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk({ssd_n, act, pmode, irq_n, 1'b0, ec}, 8'h10);
		rd(8'h01, rd_v);
		chk(rd_v, 8'h00);
		for (int c = 0; c < 16; c++) begin
			wr(8'h11, c[7:0]);
			chk({4'h0, ec, pmode}, c[7:0]);
			chk({6'h0, lvl}, {6'h0, lvl_of(c[3:1])});
		end
		wr(8'h01, 8'h01);
		chk({6'h0, ssd_n, act}, 8'h03);
		wr(8'h01, 8'h00);
		chk({2'h0, ssd_n, act, ec, pmode}, 8'h0f);
		// Foreign address: the controller gives up at once
		i_host.start();
		i_host.put_byte(8'hac, ack_n);
		chk({7'h0, ack_n}, 8'h01);
		i_host.stop();
		for (int i = 0; i < 4; i++) begin
			prox = i[1:0];
			lat = ~i[1:0];
			repeat (3) @(negedge clk_sys);
			chk({7'h0, irq_n}, 8'h00);
			rd(8'h00, rd_v);
			chk(rd_v, {4'h0, i[1:0], ~i[1:0]});
			chk({7'h0, irq_n}, 8'h01);
		end
		wr(8'h00, 8'hff);
		rd(8'h00, rd_v);
		chk(rd_v, 8'h0c);
		lat = 2'h1;
		repeat (HOLD - 10) @(negedge clk_sys);
		chk({7'h0, irq_n}, 8'h00);
		repeat (20) @(negedge clk_sys);
		chk({7'h0, irq_n}, 8'h01);
		// Controller acks once: the same index is sent again
		i_host.start();
		i_host.put_byte({`IRMS_TARGET_ADDR, 1'b0}, ack_n);
		i_host.put_byte(8'h00, ack_n);
		i_host.start();
		i_host.put_byte({`IRMS_TARGET_ADDR, 1'b1}, ack_n);
		i_host.get_byte(rd_v, 1'b0);
		chk(rd_v, 8'h0d);
		i_host.get_byte(rd_v, 1'b1);
		chk(rd_v, 8'h0d);
		i_host.stop();
		repeat (4) @(negedge clk_sys);
		conclude();
	end
endmodule : ir_motion_sensor_i2c_regs_bench
`default_nettype wire
